// *** hw/tcou_cfg.svh ***
// Purpose: constants of the timer compare output unit
// Assumes: one compare channel, 32-bit APB, 200 MHz pclk
// Notes: offsets are byte addresses, one aligned word per register
`ifndef TCOU_CFG_SVH
`define TCOU_CFG_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define TCOU_OFS_CTRL 8'h00
`define TCOU_OFS_VLO 8'h04
`define TCOU_OFS_VHI 8'h08
`define TCOU_OFS_STAT 8'h0C
`define TCOU_OFS_MASK 8'h10
`define TCOU_OFS_STATE 8'h14

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define TCOU_MODE_LSB 0
`define TCOU_MODE_MSB 3
`define TCOU_ST_MATCH 0
`define TCOU_ST_SEV 1
`define TCOU_CTRL_RST 8'h00
`define TCOU_VAL_RST 8'h00
`define TCOU_IRQ_RST 2'h0

// ----------------------------------------------------------------
// mode codes
// ----------------------------------------------------------------
`define TCOU_M_OFF 4'h0
`define TCOU_M_TOGGLE 4'h2
`define TCOU_M_SET 4'h8
`define TCOU_M_CLEAR 4'h9
`define TCOU_M_SWINT 4'hA
`define TCOU_M_SPECIAL 4'hB

`endif

// *** hw/tcou_pkg.sv ***
// Purpose: types of the timer compare output unit
// Assumes: constants live in tcou_cfg.svh
// Notes: none
package tcou_pkg;
    typedef enum logic [1:0] {
        TCOU_RST_IDLE = 2'b01,
        TCOU_RST_ARMED = 2'b10
    } tcou_rst_e;

    typedef enum logic [2:0] {
        TCOU_SEL_CTRL,
        TCOU_SEL_VLO,
        TCOU_SEL_VHI,
        TCOU_SEL_STAT,
        TCOU_SEL_MASK,
        TCOU_SEL_STATE,
        TCOU_SEL_NONE
    } tcou_sel_e;

    typedef logic [15:0] tcou_word_t;
endpackage

// *** hw/tcou_cmp_if.sv ***
// Purpose: carries compare value, timer count and match results
// Assumes: all signals on pclk
// Notes: none
`timescale 1ns/1ps
interface tcou_cmp_if;
    tcou_pkg::tcou_word_t value;
    tcou_pkg::tcou_word_t count;
    logic hit;
    logic hit_pulse;
    modport ctl (output value, output count, input hit, input hit_pulse);
    modport unit (input value, input count, output hit, output hit_pulse);
endinterface

// *** hw/tcou_match.sv ***
// Purpose: equality detector between compare value and timer count
// Assumes: timer count is produced on pclk
// Notes: hit_pulse marks the first cycle of each equality
`timescale 1ns/1ps
module tcou_match (
    input wire logic pclk,
    input wire logic presetn,
    tcou_cmp_if.unit cmp
);
    // ----------------------------------------------------------------
    // equality
    // ----------------------------------------------------------------
    // a slow timer holds one count for many pclk cycles, so only the
    // first cycle of equality is an event
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp.hit <= 1'b0;
            cmp.hit_pulse <= 1'b0;
        end else begin
            cmp.hit <= (cmp.value == cmp.count);
            cmp.hit_pulse <= (cmp.value == cmp.count) && !cmp.hit;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    // the release edge still runs the reset branch, so no attempt starts there
    property p_equal_track;
        @(posedge pclk) disable iff (!presetn)
        presetn |=> (cmp.hit == $past(cmp.value == cmp.count));
    endproperty
    a_equal_track: assert property (p_equal_track) else $error("hit does not track equality");

    cover property (@(posedge pclk) disable iff (!presetn) cmp.hit_pulse);
endmodule // tcou_match

// *** hw/tcou_top.sv ***
// Purpose: one compare channel against a shared 16-bit timer, APB registers
// Assumes: timer count and timer tick come from logic on pclk
// Notes: timer_reset is a reload request, not an overflow
`timescale 1ns/1ps
`include "tcou_cfg.svh"
module tcou_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] timer_count,
    input wire logic timer_tick,
    input wire logic adc_enabled,
    output logic cmp_out,
    output logic cmp_drive,
    output logic special_event,
    output logic adc_start,
    output logic timer_reset,
    output logic irq
);
    // ----------------------------------------------------------------
    // register state
    // ----------------------------------------------------------------
    logic [7:0] ctrl;
    logic [7:0] val_lo;
    logic [7:0] val_hi;
    logic [1:0] status;
    logic [1:0] mask;
    tcou_pkg::tcou_rst_e rst_state;
    tcou_pkg::tcou_sel_e sel;
    logic [3:0] mode;
    logic acc_done;
    logic wr_done;
    logic rd_done;
    logic [1:0] next_status;
    logic [1:0] next_mask;

    tcou_cmp_if cmp ();

    assign cmp.value = {val_hi, val_lo};
    assign cmp.count = timer_count;
    assign mode = ctrl[`TCOU_MODE_MSB:`TCOU_MODE_LSB];

    tcou_match u_match (
        .pclk(pclk),
        .presetn(presetn),
        .cmp(cmp)
    );

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    function automatic tcou_pkg::tcou_sel_e decode(input logic [7:0] addr);
        case (addr)
            `TCOU_OFS_CTRL: decode = tcou_pkg::TCOU_SEL_CTRL;
            `TCOU_OFS_VLO: decode = tcou_pkg::TCOU_SEL_VLO;
            `TCOU_OFS_VHI: decode = tcou_pkg::TCOU_SEL_VHI;
            `TCOU_OFS_STAT: decode = tcou_pkg::TCOU_SEL_STAT;
            `TCOU_OFS_MASK: decode = tcou_pkg::TCOU_SEL_MASK;
            `TCOU_OFS_STATE: decode = tcou_pkg::TCOU_SEL_STATE;
            default: decode = tcou_pkg::TCOU_SEL_NONE;
        endcase
    endfunction

    assign sel = decode(paddr);
    assign acc_done = psel && penable && pready;
    assign wr_done = acc_done && pwrite;
    assign rd_done = acc_done && !pwrite;

    // ----------------------------------------------------------------
    // apb handshake
    // ----------------------------------------------------------------
    // one wait-free access cycle; read data sampled in setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && (sel == tcou_pkg::TCOU_SEL_NONE);
            if (psel && !penable) begin
                case (sel)
                    tcou_pkg::TCOU_SEL_CTRL: prdata <= {24'h00_0000, ctrl};
                    tcou_pkg::TCOU_SEL_VLO: prdata <= {24'h00_0000, val_lo};
                    tcou_pkg::TCOU_SEL_VHI: prdata <= {24'h00_0000, val_hi};
                    tcou_pkg::TCOU_SEL_STAT: prdata <= {30'h0000_0000, status};
                    tcou_pkg::TCOU_SEL_MASK: prdata <= {30'h0000_0000, mask};
                    tcou_pkg::TCOU_SEL_STATE: begin
                        prdata <= {29'h0000_0000, rst_state == tcou_pkg::TCOU_RST_ARMED,
                                   cmp_drive, cmp_out};
                    end
                    default: prdata <= 32'h0000_0000;
                endcase
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // ----------------------------------------------------------------
    // software registers
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= `TCOU_CTRL_RST;
            val_lo <= `TCOU_VAL_RST;
            val_hi <= `TCOU_VAL_RST;
            mask <= `TCOU_IRQ_RST;
        end else if (wr_done) begin
            case (sel)
                tcou_pkg::TCOU_SEL_CTRL: ctrl <= pwdata[7:0];
                tcou_pkg::TCOU_SEL_VLO: val_lo <= pwdata[7:0];
                tcou_pkg::TCOU_SEL_VHI: val_hi <= pwdata[7:0];
                tcou_pkg::TCOU_SEL_MASK: mask <= pwdata[1:0];
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // output latch and pin ownership
    // ----------------------------------------------------------------
    // the pin direction itself belongs to the port logic outside; the
    // channel only says whether it owns the pin value
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_out <= 1'b0;
            cmp_drive <= 1'b0;
        end else if (wr_done && sel == tcou_pkg::TCOU_SEL_CTRL && pwdata[7:0] == 8'h00) begin
            cmp_out <= 1'b0;
            cmp_drive <= 1'b0;
        end else begin
            cmp_drive <= (mode == `TCOU_M_TOGGLE) || (mode == `TCOU_M_SET) ||
                         (mode == `TCOU_M_CLEAR);
            if (cmp.hit_pulse) begin
                case (mode)
                    `TCOU_M_TOGGLE: cmp_out <= !cmp_out;
                    `TCOU_M_SET: cmp_out <= 1'b1;
                    `TCOU_M_CLEAR: cmp_out <= 1'b0;
                    default: cmp_out <= cmp_out;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // special event trigger and deferred timer reset
    // ----------------------------------------------------------------
    // the reset waits for the timer's own edge and rechecks the match there,
    // so a compare value moved in between cancels it; the pulse is a reload
    // and is kept apart from any overflow indication
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            special_event <= 1'b0;
            adc_start <= 1'b0;
            timer_reset <= 1'b0;
            rst_state <= tcou_pkg::TCOU_RST_IDLE;
        end else begin
            special_event <= cmp.hit_pulse && mode == `TCOU_M_SPECIAL;
            adc_start <= cmp.hit_pulse && mode == `TCOU_M_SPECIAL && adc_enabled;
            timer_reset <= 1'b0;
            case (rst_state)
                tcou_pkg::TCOU_RST_IDLE: begin
                    if (cmp.hit_pulse && mode == `TCOU_M_SPECIAL) begin
                        rst_state <= tcou_pkg::TCOU_RST_ARMED;
                    end
                end
                tcou_pkg::TCOU_RST_ARMED: begin
                    if (timer_tick) begin
                        timer_reset <= cmp.hit && (cmp.value == timer_count);
                        rst_state <= tcou_pkg::TCOU_RST_IDLE;
                    end
                end
                default: rst_state <= tcou_pkg::TCOU_RST_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // status, clear on read, interrupt
    // ----------------------------------------------------------------
    // a new event in the cycle of the clearing read survives
    always_comb begin
        next_status = status;
        if (rd_done && sel == tcou_pkg::TCOU_SEL_STAT) begin
            next_status = 2'h0;
        end
        if (cmp.hit_pulse && mode != `TCOU_M_OFF) begin
            next_status[`TCOU_ST_MATCH] = 1'b1;
        end
        if (cmp.hit_pulse && mode == `TCOU_M_SPECIAL) begin
            next_status[`TCOU_ST_SEV] = 1'b1;
        end
    end

    // irq uses the mask as it stands after this edge, so a mask write and
    // the interrupt never disagree for a cycle
    always_comb begin
        next_mask = mask;
        if (wr_done && sel == tcou_pkg::TCOU_SEL_MASK) begin
            next_mask = pwdata[1:0];
        end
    end

    // matching stops with pclk, which is the intended behaviour in sleep
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status <= `TCOU_IRQ_RST;
            irq <= 1'b0;
        end else begin
            status <= next_status;
            irq <= |(next_status & next_mask);
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_flag_with_action;
        cmp.hit_pulse && mode != `TCOU_M_OFF && !wr_done |=> status[`TCOU_ST_MATCH];
    endproperty
    a_flag_with_action: assert property (p_flag_with_action) else $error("match flag missed");

    property p_set_out;
        cmp.hit_pulse && mode == `TCOU_M_SET && !wr_done |=> cmp_out;
    endproperty
    a_set_out: assert property (p_set_out) else $error("set mode left output low");

    property p_clear_out;
        cmp.hit_pulse && mode == `TCOU_M_CLEAR |=> !cmp_out;
    endproperty
    a_clear_out: assert property (p_clear_out) else $error("clear mode left output high");

    property p_toggle_out;
        cmp.hit_pulse && mode == `TCOU_M_TOGGLE && !wr_done |=> cmp_out != $past(cmp_out);
    endproperty
    a_toggle_out: assert property (p_toggle_out) else $error("toggle mode did not toggle");

    property p_swint_nopin;
        (mode == `TCOU_M_SWINT) [*2] |-> !cmp_drive;
    endproperty
    a_swint_nopin: assert property (p_swint_nopin) else $error("pin driven in swint mode");

    property p_ctrl_zero;
        wr_done && sel == tcou_pkg::TCOU_SEL_CTRL && pwdata[7:0] == 8'h00
            |=> !cmp_out && !cmp_drive;
    endproperty
    a_ctrl_zero: assert property (p_ctrl_zero) else $error("zero control kept latch");

    property p_trigger_now;
        cmp.hit_pulse && mode == `TCOU_M_SPECIAL |=> special_event && !timer_reset;
    endproperty
    a_trigger_now: assert property (p_trigger_now) else $error("trigger late or reset early");

    property p_adc_start;
        adc_start |-> special_event && $past(adc_enabled);
    endproperty
    a_adc_start: assert property (p_adc_start) else $error("adc start without trigger");

    property p_reset_cause;
        timer_reset |-> $past(timer_tick) && $past(cmp.hit)
            && $past(rst_state == tcou_pkg::TCOU_RST_ARMED);
    endproperty
    a_reset_cause: assert property (p_reset_cause) else $error("timer reset without cause");

    property p_irq_level;
        ##1 (irq == |(status & mask));
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("irq disagrees with status");

    property p_drive_modes;
        cmp_drive |-> $past(mode == `TCOU_M_TOGGLE || mode == `TCOU_M_SET
            || mode == `TCOU_M_CLEAR);
    endproperty
    a_drive_modes: assert property (p_drive_modes) else $error("pin owned in wrong mode");

    property p_off_quiet;
        cmp.hit_pulse && mode == `TCOU_M_OFF && !wr_done
            |=> $stable(cmp_out) && !special_event;
    endproperty
    a_off_quiet: assert property (p_off_quiet) else $error("off mode acted on match");

    property p_sev_flag;
        special_event |-> status[`TCOU_ST_SEV] && status[`TCOU_ST_MATCH];
    endproperty
    a_sev_flag: assert property (p_sev_flag) else $error("trigger without flags");

    property p_adc_gate;
        special_event && $past(adc_enabled) |-> adc_start;
    endproperty
    a_adc_gate: assert property (p_adc_gate) else $error("enabled converter not started");

    property p_reset_pulse;
        timer_reset |=> !timer_reset;
    endproperty
    a_reset_pulse: assert property (p_reset_pulse) else $error("timer reset held too long");

    c_special: cover property (special_event ##[1:50] timer_reset);
    c_cancel: cover property (rst_state == tcou_pkg::TCOU_RST_ARMED && timer_tick && !cmp.hit);
    c_toggle: cover property (cmp.hit_pulse && mode == `TCOU_M_TOGGLE);
    c_irq: cover property ($rose(irq));
endmodule // tcou_top

// *** verification/tcou_timer_model.sv ***
// Purpose: shared 16-bit timer and converter start counter facing the compare channel
// Assumes: timer runs on pclk, one tick every four pclk cycles while run is high
// Notes: load lets the bench place the count exactly on or off the compare value
`timescale 1ns/1ps
module tcou_timer_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic load_en,
    input wire logic [15:0] load_val,
    input wire logic timer_reset,
    input wire logic adc_start,
    output logic [15:0] timer_count,
    output logic timer_tick,
    output logic overflow_flag,
    output logic [7:0] adc_count
);
    logic [1:0] div;

    // --------------------------------------------------------
    // timer clock
    // --------------------------------------------------------
    // tick derived from pclk, never pclk itself, so every match is seen
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div <= 2'h0;
            timer_tick <= 1'b0;
        end else begin
            div <= run ? div + 2'h1 : 2'h0;
            timer_tick <= run && (div == 2'h3);
        end
    end

    // --------------------------------------------------------
    // count, overflow and converter
    // --------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_count <= 16'h0000;
            overflow_flag <= 1'b0;
            adc_count <= 8'h00;
        end else begin
            if (load_en) begin
                timer_count <= load_val;
            end else if (timer_reset) begin
                // reload is not a wrap, so the overflow flag stays put
                timer_count <= 16'h0000;
            end else if (timer_tick) begin
                timer_count <= timer_count + 16'h0001;
                if (timer_count == 16'hFFFF) begin
                    overflow_flag <= 1'b1;
                end
            end
            if (adc_start) begin
                adc_count <= adc_count + 8'h01;
            end
        end
    end
endmodule // tcou_timer_model

// *** verification/tb.sv ***
// Purpose: self-checking bench of the compare channel over APB
// Assumes: register map and mode codes of tcou_cfg.svh
// Notes: equality is made by loading the timer, so no long counting is needed
`timescale 1ns/1ps
`include "tcou_cfg.svh"
module tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr, adc_count;
    logic [31:0] pwdata, prdata, rd;
    logic timer_tick, adc_enabled, cmp_out, cmp_drive, special_event, adc_start;
    logic timer_reset, irq, run, load_en, ovf;
    logic [15:0] timer_count, load_val;
    int err_total = 0;
    int compares = 0;
    int sev_n = 0;
    int trst_n = 0;

    tcou_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timer_count(timer_count), .timer_tick(timer_tick),
        .adc_enabled(adc_enabled), .cmp_out(cmp_out), .cmp_drive(cmp_drive),
        .special_event(special_event), .adc_start(adc_start), .timer_reset(timer_reset),
        .irq(irq));
    tcou_timer_model tmr_u (.pclk(pclk), .presetn(presetn), .run(run), .load_en(load_en),
        .load_val(load_val), .timer_reset(timer_reset), .adc_start(adc_start),
        .timer_count(timer_count), .timer_tick(timer_tick), .overflow_flag(ovf),
        .adc_count(adc_count));

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        sev_n <= sev_n + int'(special_event === 1'b1);
        trst_n <= trst_n + int'(timer_reset === 1'b1);
    end

    // --------------------------------------------------------
    // helpers
    // --------------------------------------------------------
    task automatic wrap_up();
        if (err_total == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // entered just after an edge; leaves one idle cycle so psel is never set twice at once
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            err_total++;
            wrap_up();
        end else begin
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, exp);
    endtask

    task automatic load(input logic [15:0] v);
        load_en <= 1'b1;
        load_val <= v;
        @(posedge pclk);
        load_en <= 1'b0;
        @(posedge pclk);
    endtask

    // --------------------------------------------------------
    // scenarios
    // --------------------------------------------------------
    task automatic t_regs();
        rd_chk(`TCOU_OFS_CTRL, 32'h0000_0000);
        rd_chk(`TCOU_OFS_STAT, 32'h0000_0000);
        rd_chk(`TCOU_OFS_MASK, 32'h0000_0000);
        apb(1'b1, 8'h18, 32'h0000_00FF);
        chk(32'(err), 32'h0000_0001);
        rd_chk(8'h18, 32'h0000_0000);
        apb(1'b1, `TCOU_OFS_VLO, 32'h0000_01A5);
        rd_chk(`TCOU_OFS_VLO, 32'h0000_00A5);
        apb(1'b1, `TCOU_OFS_VHI, 32'h0000_0012);
        rd_chk(`TCOU_OFS_VHI, 32'h0000_0012);
    endtask

    task automatic t_miss();
        apb(1'b1, `TCOU_OFS_CTRL, 32'h0000_000A);
        load(16'h02A5);
        repeat (6) @(posedge pclk);
        rd_chk(`TCOU_OFS_STAT, 32'h0000_0000);
        load(16'h12A4);
        repeat (6) @(posedge pclk);
        rd_chk(`TCOU_OFS_STAT, 32'h0000_0000);
    endtask

    // equality is held, so six cycles cover detect, action and the irq register
    task automatic t_pin(input logic [3:0] mode, input logic out, input logic drv,
        input logic irq_exp, input logic [31:0] stat);
        apb(1'b1, `TCOU_OFS_CTRL, {28'h000_0000, mode});
        load(16'h0000);
        load(16'h12A5);
        repeat (6) @(posedge pclk);
        chk(32'(cmp_out), 32'(out));
        chk(32'(cmp_drive), 32'(drv));
        chk(32'(irq), 32'(irq_exp));
        rd_chk(`TCOU_OFS_STAT, stat);
        repeat (2) @(posedge pclk);
        chk(32'(irq), 32'h0000_0000);
    endtask

    task automatic t_special(input logic adc_en, input logic change);
        int s0;
        int t0;
        logic [7:0] a0;
        adc_enabled <= adc_en;
        apb(1'b1, `TCOU_OFS_CTRL, {28'h000_0000, `TCOU_M_SPECIAL});
        load(16'h0000);
        s0 = sev_n;
        t0 = trst_n;
        a0 = adc_count;
        load(16'h12A5);
        repeat (4) @(posedge pclk);
        chk(32'(sev_n - s0), 32'h0000_0001);
        chk(32'(cmp_drive), 32'h0000_0000);
        chk(32'(adc_count - a0), 32'(adc_en));
        if (change) begin
            apb(1'b1, `TCOU_OFS_VLO, 32'h0000_00A0);
        end
        run <= 1'b1;
        repeat (10) @(posedge pclk);
        run <= 1'b0;
        repeat (2) @(posedge pclk);
        chk(32'(trst_n - t0), 32'(!change));
        chk(32'(ovf), 32'h0000_0000);
        rd_chk(`TCOU_OFS_STAT, 32'h0000_0003);
        apb(1'b1, `TCOU_OFS_VLO, 32'h0000_00A5);
    endtask

    task automatic t_clear();
        apb(1'b1, `TCOU_OFS_CTRL, 32'h0000_0000);
        @(posedge pclk);
        chk(32'(cmp_out), 32'h0000_0000);
        rd_chk(`TCOU_OFS_STATE, 32'h0000_0000);
    endtask

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        adc_enabled = 1'b0;
        run = 1'b0;
        load_en = 1'b0;
        load_val = 16'h0000;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_miss();
        apb(1'b1, `TCOU_OFS_MASK, 32'h0000_0001);
        t_pin(`TCOU_M_SET, 1'b1, 1'b1, 1'b1, 32'h0000_0001);
        t_pin(`TCOU_M_CLEAR, 1'b0, 1'b1, 1'b1, 32'h0000_0001);
        t_pin(`TCOU_M_TOGGLE, 1'b1, 1'b1, 1'b1, 32'h0000_0001);
        t_pin(`TCOU_M_TOGGLE, 1'b0, 1'b1, 1'b1, 32'h0000_0001);
        apb(1'b1, `TCOU_OFS_MASK, 32'h0000_0000);
        t_pin(`TCOU_M_SWINT, 1'b0, 1'b0, 1'b0, 32'h0000_0001);
        t_pin(4'h5, 1'b0, 1'b0, 1'b0, 32'h0000_0001);
        t_pin(`TCOU_M_SET, 1'b1, 1'b1, 1'b0, 32'h0000_0001);
        t_clear();
        t_pin(`TCOU_M_OFF, 1'b0, 1'b0, 1'b0, 32'h0000_0000);
        t_special(1'b1, 1'b0);
        t_special(1'b0, 1'b1);
        wrap_up();
    end
endmodule // tb
